// ===== mmi_consts.vh
// constants for the midi message interpreter
`ifndef MMI_CONSTS_VH
`define MMI_CONSTS_VH
`define MMI_ST_NOTE_OFF 4'h8
`define MMI_ST_NOTE_ON 4'h9
`define MMI_ST_POLY_PRESS 4'hA
`define MMI_ST_CTRL 4'hB
`define MMI_ST_PROGRAM 4'hC
`define MMI_ST_CHAN_PRESS 4'hD
`define MMI_ST_BEND 4'hE
`define MMI_ST_SYSTEM 4'hF
`define MMI_SYS_EXCL 8'hF0
`define MMI_SYS_QFRAME 8'hF1
`define MMI_SYS_SONG_POS 8'hF2
`define MMI_SYS_SONG_SEL 8'hF3
`define MMI_SYS_EXCL_END 8'hF7
`define MMI_RT_CLOCK 8'hF8
`define MMI_RT_START 8'hFA
`define MMI_RT_CONTINUE 8'hFB
`define MMI_RT_STOP 8'hFC
`define MMI_CC_LSB_BASE 7'h20
`define MMI_CC_SWITCH_BASE 7'h40
`define MMI_CC_SUSTAIN 7'h40
`define MMI_CC_PORTAMENTO 7'h41
`define MMI_CC_DATA_INC 7'h60
`define MMI_CC_DATA_DEC 7'h61
`define MMI_CC_NRPN_MSB 7'h62
`define MMI_CC_NRPN_LSB 7'h63
`define MMI_CC_RPN_MSB 7'h64
`define MMI_CC_RPN_LSB 7'h65
`define MMI_CC_RESET_ALL 7'h79
`define MMI_CC_LOCAL 7'h7A
`define MMI_CC_ALL_OFF 7'h7B
`define MMI_CC_OMNI_OFF 7'h7C
`define MMI_CC_OMNI_ON 7'h7D
`define MMI_CC_MONO 7'h7E
`define MMI_CC_POLY 7'h7F
`define MMI_VAL_OFF 7'h00
`define MMI_VAL_ON 7'h7F
`define MMI_BEND_CENTRE 14'h2000
`define MMI_PARAM_NULL 14'h3FFF
`define MMI_CLOCKS_PER_BEAT 3'h6
`define MMI_MANUFACTURER_ID 7'h5A
`endif

// ===== mmi_sysex_filter.v
// exclusive-message filter that passes only data addressed to this maker
`timescale 1ns/1ns
`default_nettype none
`include "mmi_consts.vh"
module mmi_sysex_filter #(
  parameter [6:0] MAKER_ID = `MMI_MANUFACTURER_ID // arbitrary value
) (
  input wire clk_sys_i, // system clock
  input wire rst_i, // async reset, active high
  input wire begin_i, // exclusive status byte seen
  input wire end_i, // exclusive message ended
  input wire data_valid_i, // data byte inside exclusive
  input wire [6:0] data_i, // data byte value
  output reg [6:0] data_o, // accepted data byte
  output reg data_valid_o, // accepted data strobe
  output reg end_o // end of an accepted message
);
  reg first_q;
  reg match_q;

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      first_q <= 1'b0;
      match_q <= 1'b0;
      data_o <= 7'h00;
      data_valid_o <= 1'b0;
      end_o <= 1'b0;
    end
    else
    begin
      data_valid_o <= 1'b0;
      end_o <= 1'b0;
      if (begin_i)
      begin
        first_q <= 1'b1;
        match_q <= 1'b0;
      end
      else if (end_i)
      begin
        end_o <= match_q;
        first_q <= 1'b0;
        match_q <= 1'b0;
      end
      else if (data_valid_i)
      begin
        // the id byte decides the whole message; foreign data is dropped
        if (first_q)
        begin
          first_q <= 1'b0;
          match_q <= (data_i == MAKER_ID); // RULE_21
        end
        else if (match_q)
        begin
          data_o <= data_i; // RULE_21
          data_valid_o <= 1'b1;
        end
      end
    end
  end
endmodule // mmi_sysex_filter
`default_nettype wire

// ===== mmi_interp.v
// midi byte-stream interpreter: channel voice, mode and system messages
`timescale 1ns/1ns
`default_nettype none
`include "mmi_consts.vh"
// Overview of operation
// RULE_01: note number 0..127, middle C is 60
// RULE_02: note-off decoded as key release
// RULE_03: velocity zero note-on becomes note-off
// RULE_04: omni accepts all channels, else assigned
// RULE_05: mono sounds one voice, poly all
// RULE_06: channel pressure single, poly pressure per key
// RULE_07: program change selects one of 128
// RULE_08: system messages ignore channel and omni
// RULE_09: controllers 32..63 are LSBs of 0..31
// RULE_10: sustain and portamento are two-state switches
// RULE_11: controllers 100/101 latch registered parameter
// RULE_12: controllers 98/99 latch non-registered parameter
// RULE_13: controllers 96/97 step parameter up/down
// RULE_14: controller 123 value 0 releases notes
// RULE_15: reset controllers and local control on/off
// RULE_16: omni off/on, mono and poly selection
// RULE_17: song position relocates the sequencer
// RULE_18: follower advances one clock per 1/24 quarter
// RULE_19: start plays from song beginning
// RULE_20: stop halts, continue resumes in place
// RULE_21: exclusive data acted on only if ours
// RULE_22: thru output copies input unchanged
// RULE_23: status/data split and data byte collection
module mmi_interp (
  input wire clk_sys_i, // system clock, 100 MHz
  input wire rst_i, // async reset, active high
  input wire [7:0] rx_byte_i, // received byte
  input wire rx_valid_i, // received byte strobe
  input wire [3:0] base_chan_i, // assigned receive channel
  output reg [7:0] thru_byte_o, // thru copy of input byte
  output reg thru_valid_o, // thru copy strobe
  output reg note_valid_o, // note event strobe
  output reg note_on_o, // 1 key down, 0 key release
  output reg [6:0] note_num_o, // note number
  output reg [6:0] note_vel_o, // velocity
  output reg [3:0] note_chan_o, // channel of the note
  output reg all_off_o, // release all notes strobe
  output reg press_valid_o, // pressure strobe
  output reg press_poly_o, // 1 per-key, 0 channel-wide
  output reg [6:0] press_key_o, // key of poly pressure
  output reg [6:0] press_val_o, // pressure value
  output reg prog_valid_o, // program change strobe
  output reg [6:0] prog_num_o, // program number
  output reg [13:0] bend_o, // pitch bend, centre 0x2000
  output reg bend_valid_o, // pitch bend strobe
  output reg ctrl_valid_o, // 14-bit controller update strobe
  output reg [4:0] ctrl_index_o, // controller 0..31
  output reg [13:0] ctrl_word_o, // msb:lsb value
  output reg sustain_o, // sustain pedal state
  output reg portamento_o, // portamento switch state
  output reg [13:0] param_num_o, // selected parameter number
  output reg param_nrpn_o, // 1 non-registered selected
  output reg param_step_o, // parameter step strobe
  output reg param_up_o, // step direction, 1 up
  output reg local_ctrl_o, // local keyboard control
  output reg omni_o, // omni on
  output reg mono_o, // mono mode
  output reg [4:0] mono_count_o, // mono channel count
  output reg [6:0] voice_limit_o, // voices allocator may use
  output reg playing_o, // transport running
  output reg [13:0] song_pos_o, // beats since song start
  output reg tick_o, // one timing clock advanced
  output reg [6:0] sysex_data_o, // accepted exclusive data
  output reg sysex_valid_o, // accepted exclusive strobe
  output reg sysex_end_o // accepted exclusive ended
);
  localparam [6:0] ALL_VOICES = 7'h7F;
  localparam [6:0] ONE_VOICE = 7'h01;

  reg [7:0] run_q;
  reg have_q;
  reg [6:0] d1_q;
  reg [2:0] sub_q;
  reg [31:0] msb_ok_q;
  reg [6:0] msb_mem [0:31];

  wire is_status = rx_byte_i[7];
  wire is_rt = (rx_byte_i[7:3] == 5'h1F);
  wire [3:0] kind = run_q[7:4];
  wire in_excl = (run_q == `MMI_SYS_EXCL);
  wire one_byte = (kind == `MMI_ST_PROGRAM) || (kind == `MMI_ST_CHAN_PRESS) ||
                  (run_q == `MMI_SYS_QFRAME) || (run_q == `MMI_SYS_SONG_SEL);
  wire data_in = rx_valid_i && !is_status;
  wire done = data_in && run_q[7] && !in_excl && (have_q || one_byte); // RULE_23
  wire [6:0] d1 = one_byte ? rx_byte_i[6:0] : d1_q;
  wire [6:0] d2 = rx_byte_i[6:0];
  wire is_sys = (kind == `MMI_ST_SYSTEM);
  wire chan_ok = omni_o || (run_q[3:0] == base_chan_i); // RULE_04
  wire act_chan = done && !is_sys && chan_ok;
  wire act_sys = done && is_sys; // RULE_08
  wire excl_begin = rx_valid_i && (rx_byte_i == `MMI_SYS_EXCL);
  wire excl_end = rx_valid_i && is_status && !is_rt && in_excl && !excl_begin;
  wire reset_ctrls = act_chan && (kind == `MMI_ST_CTRL) && (d1 == `MMI_CC_RESET_ALL) && (d2 == 7'h00);
  wire msb_write = act_chan && (kind == `MMI_ST_CTRL) && (d1 < `MMI_CC_LSB_BASE);
  wire [6:0] f_data;
  wire f_valid;
  wire f_end;

  mmi_sysex_filter u_filter (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .begin_i(excl_begin),
    .end_i(excl_end),
    .data_valid_i(data_in && in_excl),
    .data_i(rx_byte_i[6:0]),
    .data_o(f_data),
    .data_valid_o(f_valid),
    .end_o(f_end)
  );

  // msb store has no reset; validity bits make it read as zero after reset
  always @(posedge clk_sys_i)
  begin
    if (msb_write)
    begin
      msb_mem[d1[4:0]] <= d2;
    end
  end

  // thru path bypasses all decoding so the stream leaves untouched
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      thru_byte_o <= 8'h00;
      thru_valid_o <= 1'b0;
      sysex_data_o <= 7'h00;
      sysex_valid_o <= 1'b0;
      sysex_end_o <= 1'b0;
    end
    else
    begin
      thru_byte_o <= rx_byte_i; // RULE_22
      thru_valid_o <= rx_valid_i; // RULE_22
      sysex_data_o <= f_data;
      sysex_valid_o <= f_valid;
      sysex_end_o <= f_end;
    end
  end

  // parser: running status kept for channel messages, real-time bytes pass through
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_q <= 8'h00;
      have_q <= 1'b0;
      d1_q <= 7'h00;
    end
    else if (rx_valid_i)
    begin
      if (is_status)
      begin
        if (!is_rt)
        begin
          run_q <= (rx_byte_i == `MMI_SYS_EXCL_END) ? 8'h00 : rx_byte_i; // RULE_23
          have_q <= 1'b0;
        end
      end
      else if (run_q[7] && !in_excl)
      begin
        if (done)
        begin
          have_q <= 1'b0;
          if (is_sys)
          begin
            run_q <= 8'h00;
          end
        end
        else
        begin
          d1_q <= rx_byte_i[6:0]; // RULE_23
          have_q <= 1'b1;
        end
      end
    end
  end

  // channel message actions
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      note_valid_o <= 1'b0;
      note_on_o <= 1'b0;
      note_num_o <= 7'h00;
      note_vel_o <= 7'h00;
      note_chan_o <= 4'h0;
      all_off_o <= 1'b0;
      press_valid_o <= 1'b0;
      press_poly_o <= 1'b0;
      press_key_o <= 7'h00;
      press_val_o <= 7'h00;
      prog_valid_o <= 1'b0;
      prog_num_o <= 7'h00;
      bend_o <= `MMI_BEND_CENTRE;
      bend_valid_o <= 1'b0;
      ctrl_valid_o <= 1'b0;
      ctrl_index_o <= 5'h00;
      ctrl_word_o <= 14'h0000;
      sustain_o <= 1'b0;
      portamento_o <= 1'b0;
      param_num_o <= `MMI_PARAM_NULL;
      param_nrpn_o <= 1'b0;
      param_step_o <= 1'b0;
      param_up_o <= 1'b0;
      local_ctrl_o <= 1'b1;
      omni_o <= 1'b1;
      mono_o <= 1'b0;
      mono_count_o <= 5'h00;
      voice_limit_o <= ALL_VOICES;
      msb_ok_q <= 32'h00000000;
    end
    else
    begin
      note_valid_o <= 1'b0;
      all_off_o <= 1'b0;
      press_valid_o <= 1'b0;
      prog_valid_o <= 1'b0;
      bend_valid_o <= 1'b0;
      ctrl_valid_o <= 1'b0;
      param_step_o <= 1'b0;
      voice_limit_o <= mono_o ? ONE_VOICE : ALL_VOICES; // RULE_05
      if (act_chan)
      begin
        case (kind)
          `MMI_ST_NOTE_ON, `MMI_ST_NOTE_OFF:
          begin
            note_valid_o <= 1'b1;
            note_num_o <= d1; // RULE_01
            note_vel_o <= d2;
            note_chan_o <= run_q[3:0];
            // zero velocity on a key-down counts as a release
            note_on_o <= (kind == `MMI_ST_NOTE_ON) && (d2 != 7'h00); // RULE_02 RULE_03
          end
          `MMI_ST_POLY_PRESS:
          begin
            press_valid_o <= 1'b1;
            press_poly_o <= 1'b1; // RULE_06
            press_key_o <= d1;
            press_val_o <= d2;
          end
          `MMI_ST_CHAN_PRESS:
          begin
            press_valid_o <= 1'b1;
            press_poly_o <= 1'b0; // RULE_06
            press_val_o <= d1;
          end
          `MMI_ST_PROGRAM:
          begin
            prog_valid_o <= 1'b1;
            prog_num_o <= d1; // RULE_07
          end
          `MMI_ST_BEND:
          begin
            bend_valid_o <= 1'b1;
            bend_o <= {d2, d1};
          end
          `MMI_ST_CTRL:
          begin
            if (d1 < `MMI_CC_LSB_BASE)
            begin
              ctrl_valid_o <= 1'b1;
              ctrl_index_o <= d1[4:0];
              ctrl_word_o <= {d2, 7'h00};
              msb_ok_q[d1[4:0]] <= 1'b1;
            end
            else if (d1 < `MMI_CC_SWITCH_BASE)
            begin
              ctrl_valid_o <= 1'b1;
              ctrl_index_o <= d1[4:0]; // RULE_09
              ctrl_word_o <= {(msb_ok_q[d1[4:0]] ? msb_mem[d1[4:0]] : 7'h00), d2}; // RULE_09
            end
            else
            begin
              case (d1)
                `MMI_CC_SUSTAIN: sustain_o <= d2[6]; // RULE_10
                `MMI_CC_PORTAMENTO: portamento_o <= d2[6]; // RULE_10
                `MMI_CC_RPN_MSB:
                begin
                  param_num_o <= {d2, (param_nrpn_o ? 7'h7F : param_num_o[6:0])}; // RULE_11
                  param_nrpn_o <= 1'b0;
                end
                `MMI_CC_RPN_LSB:
                begin
                  param_num_o <= {(param_nrpn_o ? 7'h7F : param_num_o[13:7]), d2}; // RULE_11
                  param_nrpn_o <= 1'b0;
                end
                `MMI_CC_NRPN_MSB:
                begin
                  param_num_o <= {d2, (param_nrpn_o ? param_num_o[6:0] : 7'h7F)}; // RULE_12
                  param_nrpn_o <= 1'b1;
                end
                `MMI_CC_NRPN_LSB:
                begin
                  param_num_o <= {(param_nrpn_o ? param_num_o[13:7] : 7'h7F), d2}; // RULE_12
                  param_nrpn_o <= 1'b1;
                end
                `MMI_CC_DATA_INC, `MMI_CC_DATA_DEC:
                begin
                  param_step_o <= 1'b1; // RULE_13
                  param_up_o <= (d1 == `MMI_CC_DATA_INC); // RULE_13
                end
                `MMI_CC_RESET_ALL:
                begin
                  if (reset_ctrls)
                  begin
                    sustain_o <= 1'b0; // RULE_15
                    portamento_o <= 1'b0;
                    bend_o <= `MMI_BEND_CENTRE;
                    press_val_o <= 7'h00;
                    param_num_o <= `MMI_PARAM_NULL;
                    msb_ok_q <= 32'h00000000;
                  end
                end
                `MMI_CC_LOCAL:
                begin
                  if (d2 == `MMI_VAL_ON)
                  begin
                    local_ctrl_o <= 1'b1; // RULE_15
                  end
                  else if (d2 == `MMI_VAL_OFF)
                  begin
                    local_ctrl_o <= 1'b0; // RULE_15
                  end
                end
                `MMI_CC_ALL_OFF: all_off_o <= (d2 == 7'h00); // RULE_14
                `MMI_CC_OMNI_OFF: omni_o <= 1'b0; // RULE_16
                `MMI_CC_OMNI_ON: omni_o <= 1'b1; // RULE_16
                `MMI_CC_MONO:
                begin
                  if (d2 <= 7'h10)
                  begin
                    mono_o <= 1'b1; // RULE_16
                    mono_count_o <= d2[4:0];
                    if (d2 == 7'h00)
                    begin
                      omni_o <= 1'b0; // RULE_16
                    end
                  end
                end
                `MMI_CC_POLY: mono_o <= 1'b0; // RULE_16
                default:
                begin
                  ctrl_valid_o <= 1'b0;
                end
              endcase
            end
          end
          default:
          begin
            note_valid_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // transport follower: six clocks make one sixteenth-note beat
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      playing_o <= 1'b0;
      song_pos_o <= 14'h0000;
      sub_q <= 3'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (rx_valid_i && is_rt)
      begin
        case (rx_byte_i)
          `MMI_RT_START:
          begin
            playing_o <= 1'b1; // RULE_19
            song_pos_o <= 14'h0000; // RULE_19
            sub_q <= 3'h0;
          end
          `MMI_RT_STOP: playing_o <= 1'b0; // RULE_20
          `MMI_RT_CONTINUE: playing_o <= 1'b1; // RULE_20
          `MMI_RT_CLOCK:
          begin
            if (playing_o)
            begin
              tick_o <= 1'b1; // RULE_18
              if (sub_q == `MMI_CLOCKS_PER_BEAT - 3'h1)
              begin
                sub_q <= 3'h0;
                song_pos_o <= song_pos_o + 14'h0001; // RULE_18
              end
              else
              begin
                sub_q <= sub_q + 3'h1; // RULE_18
              end
            end
          end
          default:
          begin
            tick_o <= 1'b0;
          end
        endcase
      end
      else if (act_sys && (run_q == `MMI_SYS_SONG_POS))
      begin
        // the pointer only applies while stopped; continue then resumes here
        if (!playing_o)
        begin
          song_pos_o <= {d2, d1}; // RULE_17
          sub_q <= 3'h0;
        end
      end
    end
  end
endmodule // mmi_interp
`default_nettype wire

// ===== mmi_interp_props.sv
// checker for the midi message interpreter ports
`timescale 1ns/1ns
`default_nettype none
module mmi_interp_props (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic [7:0] rx_byte_i, // received byte
  input wire logic rx_valid_i, // received byte strobe
  input wire logic [7:0] thru_byte_o, // thru byte
  input wire logic thru_valid_o, // thru strobe
  input wire logic note_valid_o, // note strobe
  input wire logic note_on_o, // key down
  input wire logic [6:0] note_vel_o, // velocity
  input wire logic prog_valid_o, // program strobe
  input wire logic [6:0] prog_num_o, // program number
  input wire logic mono_o, // mono mode
  input wire logic [6:0] voice_limit_o, // voices allowed
  input wire logic tick_o, // clock advanced
  input wire logic playing_o, // transport running
  input wire logic [13:0] song_pos_o // beats
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  a_thru_copy: assert property (rx_valid_i |=> thru_valid_o && thru_byte_o == $past(rx_byte_i))
    else $error("thru byte differs from input");
  a_thru_quiet: assert property (!rx_valid_i |=> !thru_valid_o)
    else $error("thru strobe without input");
  a_note_cause: assert property (note_valid_o |-> $past(rx_valid_i) && !$past(rx_byte_i[7]))
    else $error("note event not after a data byte");
  a_vel_zero: assert property (note_valid_o && note_vel_o == 7'h00 |-> !note_on_o)
    else $error("zero velocity reported as key down");
  a_prog_value: assert property (prog_valid_o |-> prog_num_o == $past(rx_byte_i[6:0]))
    else $error("program number not the data byte");
  a_voice_follow: assert property (voice_limit_o == ($past(mono_o) ? 7'h01 : 7'h7F))
    else $error("voice limit does not follow mode");
  a_tick_cause: assert property (tick_o |-> $past(rx_valid_i) && $past(rx_byte_i) == 8'hF8)
    else $error("tick without timing clock");
  a_start_home: assert property (rx_valid_i && rx_byte_i == 8'hFA |=> playing_o && song_pos_o == 14'h0000)
    else $error("start did not play from zero");
  a_stop_halt: assert property (rx_valid_i && rx_byte_i == 8'hFC |=> !playing_o)
    else $error("stop did not halt");
  a_cont_keep: assert property (rx_valid_i && rx_byte_i == 8'hFB |=> $stable(song_pos_o) ##0 playing_o)
    else $error("continue moved position or did not run");
endmodule // mmi_interp_props
`default_nettype wire

// ===== mmi_sender_model.sv
// far-side midi sender: one byte per strobe, prompt or slow
`timescale 1ns/1ns
`default_nettype none
module mmi_sender_model (
  input wire logic clk_sys_i, // system clock
  output logic [7:0] rx_byte_o, // byte to interpreter
  output logic rx_valid_o // byte strobe
);
  initial
  begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  // caller enters just after a rising edge; gap idles between bytes
  task automatic send(input logic [7:0] b[$], input int gap);
    foreach (b[i])
    begin
      rx_byte_o = b[i];
      rx_valid_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      if (gap > 0)
      begin
        // released line shows garbage, not the last byte
        rx_valid_o = 1'b0;
        rx_byte_o = ~b[i];
        repeat (gap) @(posedge clk_sys_i);
        #1;
      end
    end
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h5C;
  endtask
endmodule // mmi_sender_model
`default_nettype wire

// ===== mmi_interp_tb.sv
// self-checking bench for the midi message interpreter
`timescale 1ns/1ns
`default_nettype none
module mmi_interp_tb;
  typedef logic [7:0] mmi_bytes_t[$];
  logic clk_sys_i = 1'b0, rst_i = 1'b1, rx_valid_i, thru_valid_o, note_valid_o, note_on_o, all_off_o;
  logic press_valid_o, press_poly_o, prog_valid_o, bend_valid_o, ctrl_valid_o, sustain_o, portamento_o;
  logic param_nrpn_o, param_step_o, param_up_o, local_ctrl_o, omni_o, mono_o, playing_o, tick_o;
  logic sysex_valid_o, sysex_end_o;
  logic [3:0] base_chan_i = 4'h3, note_chan_o;
  logic [7:0] rx_byte_i, thru_byte_o;
  logic [6:0] note_num_o, note_vel_o, press_key_o, press_val_o, prog_num_o, voice_limit_o, sysex_data_o;
  logic [4:0] ctrl_index_o, mono_count_o;
  logic [13:0] bend_o, ctrl_word_o, param_num_o, song_pos_o;
  int failures = 0, num_checks = 0, cnt[10], pos;
  logic [7:0] sent[$];
  logic [6:0] n, v;
  mmi_bytes_t clocks;
  always #5 clk_sys_i = ~clk_sys_i;
  mmi_sender_model i_mmi_sender_model (.clk_sys_i, .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i));
  mmi_interp i_mmi_interp (.clk_sys_i, .rst_i, .rx_byte_i, .rx_valid_i, .base_chan_i, .thru_byte_o,
    .thru_valid_o, .note_valid_o, .note_on_o, .note_num_o, .note_vel_o, .note_chan_o, .all_off_o,
    .press_valid_o, .press_poly_o, .press_key_o, .press_val_o, .prog_valid_o, .prog_num_o, .bend_o,
    .bend_valid_o, .ctrl_valid_o, .ctrl_index_o, .ctrl_word_o, .sustain_o, .portamento_o, .param_num_o,
    .param_nrpn_o, .param_step_o, .param_up_o, .local_ctrl_o, .omni_o, .mono_o, .mono_count_o,
    .voice_limit_o, .playing_o, .song_pos_o, .tick_o, .sysex_data_o, .sysex_valid_o, .sysex_end_o);
  // wide enough that counter-plus-field expectations are never cut
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // pulse counters cleared per message; 3 idle cycles cover the 2-cycle filter path
  task automatic msg(input mmi_bytes_t b, input int gap = 0);
    cnt = '{default: 0};
    i_mmi_interp_tb_snd(b, gap);
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic i_mmi_interp_tb_snd(input mmi_bytes_t b, input int gap);
    i_mmi_sender_model.send(b, gap);
  endtask
  always @(posedge clk_sys_i)
  begin
    if (rx_valid_i === 1'b1)
      sent.push_back(rx_byte_i);
    if (thru_valid_o === 1'b1 && sent.size() > 0)
      chk("thru", sent.pop_front(), thru_byte_o);
    cnt[0] += note_valid_o; cnt[1] += press_valid_o; cnt[2] += prog_valid_o; cnt[3] += ctrl_valid_o;
    cnt[4] += param_step_o; cnt[5] += all_off_o; cnt[6] += tick_o; cnt[7] += sysex_valid_o;
    cnt[8] += sysex_end_o; cnt[9] += bend_valid_o;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    final_report();
  end
  initial
  begin
    void'($urandom(10447));
    repeat (3) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    chk("rst", {1'b1, 1'b1, 1'b0, 7'h7F, 14'h3FFF}, {omni_o, local_ctrl_o, mono_o, voice_limit_o, param_num_o});
    msg('{8'h93, 8'h3C, 8'h40});
    chk("on", {1'b1, 7'd60, 7'd64, 4'h3}, {note_on_o, note_num_o, note_vel_o, note_chan_o});
    msg('{8'h3C, 8'h00}, 2);
    chk("vel0", {1'b0, 7'd60, 4'h3}, {note_on_o, note_num_o, note_chan_o});
    msg('{8'h83, 8'h7F, 8'h10});
    chk("off", {1'b0, 7'd127, 7'h10}, {note_on_o, note_num_o, note_vel_o});
    for (int i = 0; i < 4; i++)
    begin
      n = (i == 0) ? 7'h00 : 7'($urandom % 128);
      v = 7'(1 + $urandom % 127);
      msg('{8'h93, {1'b0, n}, {1'b0, v}}, i % 2);
      chk("rnd", {32'd1, 1'b1, n, v}, {cnt[0], note_on_o, note_num_o, note_vel_o});
    end
    msg('{8'h93, 8'h30, 8'hF8, 8'h20});
    chk("rt", {1'b1, 7'h30, 7'h20}, {note_on_o, note_num_o, note_vel_o});
    msg('{8'hB3, 8'h7C, 8'h00});
    chk("omnioff", 1'b0, omni_o);
    msg('{8'h95, 8'h10, 8'h10});
    chk("filt", 0, cnt[0]);
    msg('{8'hF0, 8'h5A, 8'h01, 8'h02, 8'hF7});
    chk("sx", {32'd2, 32'd1, 7'h02}, {cnt[7], cnt[8], sysex_data_o});
    msg('{8'hF0, 8'h11, 8'h03, 8'hF7});
    chk("sxoth", 0, cnt[7] + cnt[8]);
    msg('{8'hB3, 8'h7D, 8'h00, 8'h95, 8'h10, 8'h10});
    chk("omnion", {1'b1, 4'h5}, {omni_o, note_chan_o});
    msg('{8'hA3, 8'h22, 8'h33});
    chk("ppr", {1'b1, 7'h22, 7'h33}, {press_poly_o, press_key_o, press_val_o});
    msg('{8'hD3, 8'h44});
    chk("cpr", {1'b0, 7'h44, 32'd1}, {press_poly_o, press_val_o, cnt[1]});
    msg('{8'hC3, 8'h7F});
    chk("prog", {32'd1, 7'h7F}, {cnt[2], prog_num_o});
    msg('{8'hE3, 8'h11, 8'h45});
    chk("bend", {32'd1, 14'h2291}, {cnt[9], bend_o});
    msg('{8'hB3, 8'h07, 8'h55});
    chk("msb", {5'd7, 7'h55, 7'h00}, {ctrl_index_o, ctrl_word_o});
    msg('{8'h27, 8'h11});
    chk("lsb", {32'd1, 5'd7, 7'h55, 7'h11}, {cnt[3], ctrl_index_o, ctrl_word_o});
    msg('{8'h40, 8'h7F, 8'h41, 8'h7F});
    msg('{8'h40, 8'h00});
    chk("sw", 2'b01, {sustain_o, portamento_o});
    msg('{8'h65, 8'h02, 8'h64, 8'h01});
    chk("rpn", {1'b0, 7'h01, 7'h02}, {param_nrpn_o, param_num_o});
    msg('{8'h63, 8'h05, 8'h62, 8'h03});
    chk("nrpn", {1'b1, 7'h03, 7'h05}, {param_nrpn_o, param_num_o});
    msg('{8'h60, 8'h7F});
    chk("inc", {32'd1, 1'b1}, {cnt[4], param_up_o});
    msg('{8'h61, 8'h7F});
    chk("dec", {32'd1, 1'b0}, {cnt[4], param_up_o});
    msg('{8'h7B, 8'h00});
    chk("alloff", 1, cnt[5]);
    msg('{8'h7A, 8'h00});
    chk("loc0", 1'b0, local_ctrl_o);
    msg('{8'h7A, 8'h7F, 8'h79, 8'h00});
    chk("rstc", {1'b1, 1'b0, 14'h3FFF, 14'h2000}, {local_ctrl_o, portamento_o, param_num_o, bend_o});
    msg('{8'h7E, 8'h01});
    chk("mono", {1'b1, 7'h01, 5'd1}, {mono_o, voice_limit_o, mono_count_o});
    msg('{8'h7E, 8'h00});
    chk("mono0", {1'b0, 1'b1, 5'd0}, {omni_o, mono_o, mono_count_o});
    msg('{8'h7F, 8'h00});
    chk("poly", {1'b0, 7'h7F}, {mono_o, voice_limit_o});
    msg('{8'h7E, 8'h11});
    chk("mono17", {1'b0, 7'h7F}, {mono_o, voice_limit_o});
    msg('{8'hFA});
    chk("start", {1'b1, 14'h0000}, {playing_o, song_pos_o});
    clocks = {};
    repeat (12) clocks.push_back(8'hF8);
    msg(clocks);
    chk("clk", {32'd12, 14'd2}, {cnt[6], song_pos_o});
    msg('{8'hFC});
    chk("stop", 1'b0, playing_o);
    n = 7'($urandom % 128);
    pos = {7'h01, n};
    msg('{8'hF2, {1'b0, n}, 8'h01});
    chk("spp", pos, song_pos_o);
    msg('{8'hFB});
    msg(clocks, 1);
    chk("cont", {1'b1, 14'(pos + 2)}, {playing_o, song_pos_o});
    msg('{8'hFA});
    chk("restart", 14'h0000, song_pos_o);
    final_report();
  end
endmodule // mmi_interp_tb
bind mmi_interp mmi_interp_props i_mmi_interp_props (.clk_sys_i, .rst_i, .rx_byte_i, .rx_valid_i,
  .thru_byte_o, .thru_valid_o, .note_valid_o, .note_on_o, .note_vel_o, .prog_valid_o, .prog_num_o,
  .mono_o, .voice_limit_o, .tick_o, .playing_o, .song_pos_o);
`default_nettype wire
